// [core/dmacc_pkg.sv]
// Purpose: Shared constants for the three-channel DMA channel control block
// Assumes: 32-bit AHB-Lite register access, one aligned word per register
// Notes: Register words sit at bank*16 + reg*4; bank 3 holds the shared words
package dmacc_pkg;
   // ==========================================================
   // Sizes
   localparam int NCH = 3;               // Number of channels
   localparam int CNT_W = 16;            // Transfer count width
   // ==========================================================
   // Address decode: haddr[7:4] bank, haddr[3:2] word
   localparam logic [1:0] REG_CTL = 2'h0;   // channel_control
   localparam logic [1:0] REG_SRC = 2'h1;   // channel_source_pointer
   localparam logic [1:0] REG_DST = 2'h2;   // channel_destination_pointer
   localparam logic [1:0] REG_CNT = 2'h3;   // channel_transfer_count
   localparam logic [3:0] BANK_GLB = 4'h3;  // Shared words bank
   localparam logic [1:0] GLB_CFG = 2'h0;   // Config word (nmi_abort_enable)
   localparam logic [1:0] GLB_VEC = 2'h1;   // pending_vector_word
   // ==========================================================
   // channel_control field positions
   localparam int BIT_REQ = 0;     // software_request
   localparam int BIT_ABORT = 1;   // nmi_aborted_flag
   localparam int BIT_IE = 2;      // channel_irq_enable
   localparam int BIT_IFG = 3;     // channel_irq_flag
   localparam int BIT_EN = 4;      // channel_enable
   localparam int BIT_LEVEL = 5;   // trigger_level_select
   localparam int BIT_SRCB = 6;    // src_byte_select
   localparam int BIT_DSTB = 7;    // dest_byte_select
   localparam int SRC_LO = 8;      // src_step_select, 2 bits
   localparam int DST_LO = 10;     // dest_step_select, 2 bits
   localparam int MODE_LO = 12;    // transfer_mode_field, 3 bits
   localparam int MODE_REP = 14;   // Repeat bit of the mode field
   localparam int CTL_W = 15;      // Bit 15 is reserved, reads zero
   localparam logic [CTL_W-1:0] CTL_RST = 15'h0000;
   // ==========================================================
   // Encodings
   localparam logic [1:0] STEP_DEC = 2'h2;
   localparam logic [1:0] STEP_INC = 2'h3;
   localparam logic [2:0] MODE_SINGLE = 3'h0;
   localparam logic [15:0] VEC_NONE = 16'h0000;
   localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
   localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
   // ==========================================================
   // Mover engine states
   typedef enum logic [0:0] {
      DMACC_IDLE = 1'b0,
      DMACC_MOVE = 1'b1
   } dmacc_eng_t;
endpackage

// [core/dmacc_channel_control.sv]
// Purpose: Control, pointer and count logic of a three-channel DMA controller
// Assumes: One clock; triggers, nmiIn and memDone synchronous to clock
// Notes: Fixed priority, channel 0 first; memory mover handshakes per item
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// - NMI abort only when abort enable set
// - Mode field: zero single, nonzero block, top bit repeats
// - Destination steps one byte or two word
// - Dest step: 0x keep, 10 down, 11 up
// - Destination stepping uses working copy only
// - Source steps on working copy, register kept
// - Source step: 0x keep, 10 down, 11 up
// - Width bits per side: 0 word, 1 byte
// - Level bit: 0 rising edge, 1 high level
// - Enable bit must be set for activity
// - Per channel pending flag and enable
// - Abort flag set when NMI interrupted transfer
// - Software request starts, then self clears
// - Source pointer unchanged during block transfers
// - Destination pointer unchanged during block transfers
// - Pointer bits above address width read zero
// - Count decrements, reloads on reaching zero
// - Zero count disables, else block length
// - Vector 0, 2, 4, 6; channel 0 first
// - Vector access clears highest pending flag
// - Disabled interrupts never affect the vector
// - NMI: finish current item, stop, flag abort
module dmacc_channel_control #(
   parameter int ADDR_W = 20   // 16 for parts limited to 64 KB
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic [dmacc_pkg::NCH-1:0] trigIn,
   input wire logic nmiIn,
   output logic memValid,
   output logic [ADDR_W-1:0] memSrcAddr,
   output logic [ADDR_W-1:0] memDstAddr,
   output logic memSrcByte,
   output logic memDstByte,
   output logic [1:0] memChan,
   input wire logic memDone,
   output logic irqOut
);
   import dmacc_pkg::*;

   // ==========================================================
   // Functions
   // Lowest set index, used by arbiter and vector
   function automatic logic [1:0] firstOne(input logic [NCH-1:0] v);
      logic [1:0] idx;
      idx = 2'h0;
      for (int i = NCH - 1; i >= 0; i--) begin
         if (v[i]) begin
            idx = 2'(i);
         end
      end
      return idx;
   endfunction

   // Address step by width and direction
   function automatic logic [ADDR_W-1:0] stepAddr(input logic [ADDR_W-1:0] a,
         input logic [1:0] s, input logic isByte);
      logic [ADDR_W-1:0] d;
      d = isByte ? ADDR_W'(1) : ADDR_W'(2);
      if (s == STEP_INC) begin
         return a + d;
      end else if (s == STEP_DEC) begin
         return a - d;
      end
      return a;
   endfunction

   // ==========================================================
   // Storage
   logic [CTL_W-1:0] ctl_reg [NCH];      // Control words, reset
   logic [NCH-1:0] busy_reg;             // Block in progress
   logic [NCH-1:0] edgePend_reg;         // Caught rising edge
   logic [NCH-1:0] trigPrev_reg;         // Trigger last cycle
   logic [ADDR_W-1:0] srcPtr_reg [NCH];  // Software pointers, no reset
   logic [ADDR_W-1:0] dstPtr_reg [NCH];
   logic [ADDR_W-1:0] srcW_reg [NCH];    // Working copies
   logic [ADDR_W-1:0] dstW_reg [NCH];
   logic [CNT_W-1:0] cnt_reg [NCH];      // Live count
   logic [CNT_W-1:0] cntInit_reg [NCH];  // Last written count
   logic cfgNmi_reg;                     // nmi_abort_enable
   logic nmiHold_reg;                    // Abort waiting for idle
   dmacc_eng_t eng_reg;
   logic [1:0] actCh_reg;                // Channel being served
   // Bus data phase
   logic dpRead_reg;
   logic dpWrite_reg;
   logic rdDone_reg;
   logic [7:0] dpAddr_reg;
   logic [31:0] hrdata_reg;
   logic [ADDR_W-1:0] memSrc_reg;
   logic [ADDR_W-1:0] memDst_reg;
   logic memSrcB_reg;
   logic memDstB_reg;

   // ==========================================================
   // Bus decode
   wire apTake = hsel & hready & htrans[1];
   wire [3:0] selBank = dpAddr_reg[7:4];
   wire [1:0] selWord = dpAddr_reg[3:2];
   wire [1:0] chIdx = selBank[1:0];
   wire chHit = selBank < 4'(NCH);
   wire glbHit = selBank == BANK_GLB;
   wire rdFirst = dpRead_reg & ~rdDone_reg;
   // Either access kind of the vector counts as a service
   wire vecAccess = glbHit & (selWord == GLB_VEC) & (dpWrite_reg | rdFirst);
   wire cfgWr = dpWrite_reg & glbHit & (selWord == GLB_CFG);

   // ==========================================================
   // Per channel field views and qualifiers
   logic [NCH-1:0] chEn;
   logic [NCH-1:0] chIfg;
   logic [NCH-1:0] chIe;
   logic [NCH-1:0] chReq;
   logic [NCH-1:0] chWant;
   logic [NCH-1:0] ctlWr;
   logic [NCH-1:0] enRise;
   logic [NCH-1:0] ptrWrS;
   logic [NCH-1:0] ptrWrD;
   logic [NCH-1:0] cntWr;
   for (genvar c = 0; c < NCH; c++) begin : g_ch
      wire isCh = dpWrite_reg & chHit & (chIdx == 2'(c));
      wire trigSeen;
      assign chEn[c] = ctl_reg[c][BIT_EN];
      assign chIfg[c] = ctl_reg[c][BIT_IFG];
      assign chIe[c] = ctl_reg[c][BIT_IE];
      assign chReq[c] = ctl_reg[c][BIT_REQ];
      assign ctlWr[c] = isCh & (selWord == REG_CTL);
      assign ptrWrS[c] = isCh & (selWord == REG_SRC);
      assign ptrWrD[c] = isCh & (selWord == REG_DST);
      assign cntWr[c] = isCh & (selWord == REG_CNT);
      // Enable written from 0 to 1 copies pointers into working copies
      assign enRise[c] = ctlWr[c] & hwdata[BIT_EN] & ~chEn[c];
      // Level or caught edge
      assign trigSeen = ctl_reg[c][BIT_LEVEL] ? trigIn[c] : edgePend_reg[c];
      // Zero count keeps the channel quiet even when enabled
      assign chWant[c] = chEn[c] & (cnt_reg[c] != CNT_ZERO) & ~nmiHold_reg
         & (busy_reg[c] | chReq[c] | trigSeen);
   end

   // ==========================================================
   // Arbiter and vector
   wire idle = eng_reg == DMACC_IDLE;
   wire startGo = idle & (|chWant);
   wire [1:0] grantCh = firstOne(chWant);
   wire done = (eng_reg == DMACC_MOVE) & memDone;
   wire [CTL_W-1:0] actCtl = ctl_reg[actCh_reg];
   wire lastItem = cnt_reg[actCh_reg] == CNT_ONE;
   // Disabled interrupts are masked before priority
   wire [NCH-1:0] pendEn = chIfg & chIe;
   wire [1:0] vecIdx = firstOne(pendEn);
   wire [15:0] vecVal = (|pendEn) ? {13'h0000, 2'(vecIdx + 2'h1), 1'b0} : VEC_NONE;
   wire nmiApply = nmiHold_reg & idle;

   // ==========================================================
   // Read mux, bits above each field read zero
   wire [31:0] chRd = (selWord == REG_CTL) ? {17'h00000, ctl_reg[chIdx]} :
      (selWord == REG_SRC) ? 32'(srcPtr_reg[chIdx]) :
      (selWord == REG_DST) ? 32'(dstPtr_reg[chIdx]) :
      {16'h0000, cnt_reg[chIdx]};
   wire [31:0] glbRd = (selWord == GLB_CFG) ? {31'h00000000, cfgNmi_reg} :
      (selWord == GLB_VEC) ? {16'h0000, vecVal} : 32'h00000000;
   wire [31:0] rdMux = chHit ? chRd : (glbHit ? glbRd : 32'h00000000);

   // ==========================================================
   // AHB-Lite slave: writes zero wait, reads one wait state
   // Reads are sampled a cycle late so a write just before is seen
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         dpRead_reg <= 1'b0;
         dpWrite_reg <= 1'b0;
         rdDone_reg <= 1'b0;
         dpAddr_reg <= 8'h00;
         hrdata_reg <= 32'h00000000;
      end else if (hready) begin
         dpRead_reg <= apTake & ~hwrite;
         dpWrite_reg <= apTake & hwrite;
         dpAddr_reg <= haddr[7:0];
         rdDone_reg <= 1'b0;
      end else if (rdFirst) begin
         rdDone_reg <= 1'b1;
         hrdata_reg <= rdMux;
      end
   end
   assign hreadyout = ~rdFirst;
   assign hresp = 1'b0;
   assign hrdata = hrdata_reg;

   // ==========================================================
   // Shared config and NMI hold
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         cfgNmi_reg <= 1'b0;
         nmiHold_reg <= 1'b0;
      end else begin
         if (cfgWr) begin
            cfgNmi_reg <= hwdata[0];
         end
         // Without the enable the NMI never reaches the mover
         if (nmiIn & cfgNmi_reg) begin
            nmiHold_reg <= 1'b1;
         end else if (nmiApply) begin
            nmiHold_reg <= 1'b0;
         end
      end
   end

   // ==========================================================
   // Mover engine: one item per grant, waits for memDone
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         eng_reg <= DMACC_IDLE;
         actCh_reg <= 2'h0;
         memSrc_reg <= '0;
         memDst_reg <= '0;
         memSrcB_reg <= 1'b0;
         memDstB_reg <= 1'b0;
      end else begin
         unique case (eng_reg)
            DMACC_IDLE: begin
               if (startGo) begin
                  eng_reg <= DMACC_MOVE;
                  actCh_reg <= grantCh;
                  memSrc_reg <= srcW_reg[grantCh];
                  memDst_reg <= dstW_reg[grantCh];
                  memSrcB_reg <= ctl_reg[grantCh][BIT_SRCB];
                  memDstB_reg <= ctl_reg[grantCh][BIT_DSTB];
               end
            end
            DMACC_MOVE: begin
               // An NMI never cuts an item short
               if (memDone) begin
                  eng_reg <= DMACC_IDLE;
               end
            end
         endcase
      end
   end
   assign memValid = eng_reg == DMACC_MOVE;
   assign memSrcAddr = memSrc_reg;
   assign memDstAddr = memDst_reg;
   assign memSrcByte = memSrcB_reg;
   assign memDstByte = memDstB_reg;
   assign memChan = actCh_reg;
   assign irqOut = |pendEn;

   // ==========================================================
   // Control words; hardware sets come last so they win
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         for (int c = 0; c < NCH; c++) begin
            ctl_reg[c] <= CTL_RST;
         end
         busy_reg <= '0;
         edgePend_reg <= '0;
         trigPrev_reg <= '0;
      end else begin
         trigPrev_reg <= trigIn;
         for (int c = 0; c < NCH; c++) begin
            if (ctlWr[c]) begin
               ctl_reg[c] <= hwdata[CTL_W-1:0];
               if (!hwdata[BIT_EN]) begin
                  busy_reg[c] <= 1'b0;
               end
            end else if (!chEn[c]) begin
               ctl_reg[c][BIT_REQ] <= 1'b0;
            end
            if (!chEn[c] | ctl_reg[c][BIT_LEVEL]) begin
               edgePend_reg[c] <= 1'b0;
            end else if (trigIn[c] & ~trigPrev_reg[c]) begin
               edgePend_reg[c] <= 1'b1;
            end
            if (vecAccess && (|pendEn) && vecIdx == 2'(c)) begin
               ctl_reg[c][BIT_IFG] <= 1'b0;
            end
            // Grant consumes the request; block modes stay busy
            if (startGo && grantCh == 2'(c)) begin
               ctl_reg[c][BIT_REQ] <= 1'b0;
               edgePend_reg[c] <= 1'b0;
               busy_reg[c] <= ctl_reg[c][MODE_LO+:3] != MODE_SINGLE;
            end
            if (done && actCh_reg == 2'(c) && lastItem) begin
               ctl_reg[c][BIT_IFG] <= 1'b1;
               busy_reg[c] <= 1'b0;
               if (!ctl_reg[c][MODE_REP]) begin
                  ctl_reg[c][BIT_EN] <= 1'b0;
               end
            end
            // Only a channel caught mid-block is aborted
            if (nmiApply && busy_reg[c]) begin
               ctl_reg[c][BIT_EN] <= 1'b0;
               ctl_reg[c][BIT_ABORT] <= 1'b1;
               busy_reg[c] <= 1'b0;
            end
         end
      end
   end

   // ==========================================================
   // Pointers and counts: no reset, contents survive it
   always_ff @(posedge clock) begin
      for (int c = 0; c < NCH; c++) begin
         if (ptrWrS[c]) begin
            srcPtr_reg[c] <= hwdata[ADDR_W-1:0];
         end
         if (ptrWrD[c]) begin
            dstPtr_reg[c] <= hwdata[ADDR_W-1:0];
         end
         if (cntWr[c]) begin
            cnt_reg[c] <= hwdata[CNT_W-1:0];
            cntInit_reg[c] <= hwdata[CNT_W-1:0];
         end
         if (enRise[c]) begin
            srcW_reg[c] <= srcPtr_reg[c];
            dstW_reg[c] <= dstPtr_reg[c];
         end
      end
      // Stepping touches only working copies, never the pointers
      if (done) begin
         if (lastItem) begin
            cnt_reg[actCh_reg] <= cntInit_reg[actCh_reg];
            srcW_reg[actCh_reg] <= srcPtr_reg[actCh_reg];
            dstW_reg[actCh_reg] <= dstPtr_reg[actCh_reg];
         end else begin
            cnt_reg[actCh_reg] <= cnt_reg[actCh_reg] - CNT_ONE;
            srcW_reg[actCh_reg] <= stepAddr(srcW_reg[actCh_reg],
               actCtl[SRC_LO+:2], actCtl[BIT_SRCB]);
            dstW_reg[actCh_reg] <= stepAddr(dstW_reg[actCh_reg],
               actCtl[DST_LO+:2], actCtl[BIT_DSTB]);
         end
      end
   end

   // ==========================================================
   // Checks
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);
   wire ch0Done = done & (actCh_reg == 2'h0) & ~dpWrite_reg;

   a_req_when_off: assert property (!chEn[0] && !ctlWr[0] |=> !chReq[0])
      else $error("request kept while disabled");
   a_grant_enabled: assert property (startGo |-> chEn[grantCh])
      else $error("grant to disabled channel");
   a_ptr_kept: assert property (ch0Done |=> $stable(srcPtr_reg[0])
      && $stable(dstPtr_reg[0])) else $error("pointer changed by transfer");
   a_cnt_down: assert property (ch0Done && !lastItem
      |=> cnt_reg[0] == $past(cnt_reg[0]) - CNT_ONE) else $error("count not stepped");
   a_cnt_reload: assert property (ch0Done && lastItem
      |=> cnt_reg[0] == $past(cntInit_reg[0])) else $error("count not reloaded");
   a_dst_inc_step: assert property (ch0Done && !lastItem
      && actCtl[DST_LO+:2] == STEP_INC |=> dstW_reg[0] == $past(dstW_reg[0])
      + ($past(actCtl[BIT_DSTB]) ? ADDR_W'(1) : ADDR_W'(2))) else $error("dest step wrong");
   a_vec_first: assert property (pendEn[0] |-> vecVal == 16'h0002)
      else $error("channel 0 not first in vector");
   a_vec_clear: assert property (vecAccess && pendEn[0] && !ch0Done
      && !ctlWr[0] |=> !chIfg[0]) else $error("vector access left flag");
   a_nmi_gated: assert property (!cfgNmi_reg && !nmiHold_reg |=> !nmiHold_reg)
      else $error("NMI held while abort disabled");
   a_abort_flag: assert property (nmiApply && busy_reg[0]
      |=> ctl_reg[0][BIT_ABORT] && !chEn[0]) else $error("abort not flagged");
   a_item_finish: assert property (memValid && nmiHold_reg && !memDone
      |=> memValid) else $error("item cut short by NMI");

   c_block_end: cover property (done && lastItem && busy_reg[actCh_reg]);
   c_nmi_abort: cover property (nmiApply && (|busy_reg));
   c_vec_two: cover property (vecAccess && pendEn[0] && pendEn[2]);
   c_sw_start: cover property (startGo && chReq[grantCh]);
endmodule
`default_nettype wire

// [verification/dmacc_mem_model.sv]
// Purpose: Memory and peripheral side of the mover link, finishing each item
// Assumes: memValid stays up until memDone is seen; one item per request
// Notes: slowMode stretches every item so that an NMI can land mid-item
`timescale 1ns/1ns
`default_nettype none
module dmacc_mem_model #(
   parameter int SLOW_WAIT = 6   // Extra cycles per item when slow
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic memValid,
   input wire logic slowMode,
   output logic memDone
);
   // ==========================================================
   // Item timer
   logic [7:0] waitReg;   // Cycles spent on the current item
   // Done pulses one cycle; no second done for the same item
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         waitReg <= 8'h00;
         memDone <= 1'b0;
      end else if (memDone || !memValid) begin
         // Idle or just finished: rearm
         waitReg <= 8'h00;
         memDone <= 1'b0;
      end else if (!slowMode || waitReg == 8'(SLOW_WAIT)) begin
         memDone <= 1'b1;
      end else begin
         waitReg <= waitReg + 8'h01;
      end
   end
endmodule
`default_nettype wire

// [verification/tb.sv]
// Purpose: Self-checking bench for the three-channel DMA channel control block
// Assumes: One AHB-Lite slave, so hready is the slave's own hreadyout
// Notes: Register cases run from a table; transfers are hand-written after it
`timescale 1ns/1ns
`default_nettype none
`define CHK(what, exp, got) begin \
   comparisons++; \
   if ((got) !== (exp)) begin \
      error_cnt++; \
      $display("Error %s expected %h seen %h", what, exp, got); \
   end \
end
module tb;
   import dmacc_pkg::*;
   // ==========================================================
   // Signals
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic hsel = 1'b0;
   logic hwrite = 1'b0;
   logic [31:0] haddr = 32'h00000000;
   logic [31:0] hwdata = 32'h00000000;
   logic [1:0] htrans = 2'h0;
   logic [2:0] trigIn = 3'h0;
   logic nmiIn = 1'b0;
   logic slowMode = 1'b0;   // Stretch items for the abort case
   wire logic hready;
   logic hreadyout, hresp, memValid, memSrcByte, memDstByte, memDone, irqOut;
   logic [31:0] hrdata, rd, rdS;
   logic [19:0] memSrcAddr, memDstAddr;
   logic [1:0] memChan;
   logic rdyS;               // hreadyout as it stands before the next edge
   logic [43:0] itemQ[$], exp;    // {chan, srcByte, dstByte, src, dst} per item
   int error_cnt = 0;
   int comparisons = 0;
   int cycles = 0;
   int i, base;
   typedef struct packed {logic [31:0] a, d, e;} dmacc_row_t;
   // Address, write data, expected read-back
   const dmacc_row_t rows[8] = '{
      '{32'h00000004, 32'hFFFFFFFF, 32'h000FFFFF},   // Source pointer, top bits
      '{32'h00000018, 32'h12345678, 32'h00045678},   // Destination pointer
      '{32'h0000002C, 32'hFFFF1234, 32'h00001234},   // Count is 16 bits
      '{32'h00000000, 32'h0000FFE6, 32'h00007FE6},   // Control, bit 15 reserved
      '{32'h0000003C, 32'hFFFFFFFF, 32'h00000000},   // Unmapped word
      '{32'h00000040, 32'hA5A5A5A5, 32'h00000000},   // Unmapped bank
      '{32'h00000030, 32'h00000001, 32'h00000001},   // Config set
      '{32'h00000030, 32'h00000000, 32'h00000000}};  // Config clear
   assign hready = hreadyout;
   // ==========================================================
   // Design and far side
   dmacc_channel_control #(.ADDR_W(20)) dut (.clock(clock), .rst(rst), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
      .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .trigIn(trigIn), .nmiIn(nmiIn), .memValid(memValid), .memSrcAddr(memSrcAddr),
      .memDstAddr(memDstAddr), .memSrcByte(memSrcByte), .memDstByte(memDstByte),
      .memChan(memChan), .memDone(memDone), .irqOut(irqOut));
   dmacc_mem_model mem (.clock(clock), .rst(rst), .memValid(memValid),
      .slowMode(slowMode), .memDone(memDone));
   // ==========================================================
   // Clock, bus sampling, item log, timeout
   always #4 clock = ~clock;
   // Settled values before the edge
   always @(negedge clock) begin
      rdyS <= hreadyout;
      rdS <= hrdata;
   end
   // Log each finished item
   always @(posedge clock) begin
      if (memValid === 1'b1 && memDone === 1'b1) begin
         itemQ.push_back({memChan, memSrcByte, memDstByte, memSrcAddr, memDstAddr});
      end
   end
   // A hang counts as a mismatch
   always @(posedge clock) begin
      cycles++;
      if (cycles == 20000) begin
         error_cnt++;
         conclude();
      end
   end
   // ==========================================================
   // Tasks
   // One single word transfer; read data lands in rd
   task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
      @(posedge clock);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= a;
      do @(posedge clock); while (rdyS !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clock); while (rdyS !== 1'b1);
      rd = rdS;
   endtask
   // Bounded wait for n logged items
   task automatic waitItems(input int n);
      for (int k = 0; k < 400 && itemQ.size() < n; k++) @(posedge clock);
      repeat (4) @(posedge clock);
   endtask
   // Bounded wait for a mover request
   task automatic waitValid();
      for (int k = 0; k < 400 && memValid !== 1'b1; k++) @(posedge clock);
   endtask
   // Control word from mode, steps and the low byte
   function automatic logic [31:0] ctl(input logic [2:0] m, input logic [1:0] ds,
      input logic [1:0] ss, input logic [7:0] lo);
      return {17'h00000, m, ds, ss, lo};
   endfunction
   // Verdict; the one place the run ends
   task automatic conclude();
      $display("Comparisons %0d, errors %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // ==========================================================
   // Main sequence
   initial begin
      repeat (12) @(posedge clock);
      rst <= 1'b0;
      for (i = 0; i < 3; i++) begin
         xfer(1'b0, {24'h000000, 4'(i), 4'h0}, 32'h00000000);
         `CHK("control reset", 32'h00000000, rd);
      end
      xfer(1'b0, 32'h00000034, 32'h00000000);
      `CHK("vector reset", 32'h00000000, rd);
      `CHK("okay response", 1'b0, hresp);
      for (i = 0; i < 8; i++) begin
         xfer(1'b1, rows[i].a, rows[i].d);
         xfer(1'b0, rows[i].a, 32'h00000000);
         `CHK("register row", rows[i].e, rd);
      end
      // Block: byte source stepping down, word destination stepping up
      xfer(1'b1, 32'h00000004, 32'h00000100);
      xfer(1'b1, 32'h00000008, 32'h00000200);
      xfer(1'b1, 32'h0000000C, 32'h00000003);
      xfer(1'b1, 32'h00000000, ctl(3'h1, 2'h3, 2'h2, 8'h55));
      waitItems(3);
      for (i = 0; i < 3; i++) begin
         exp = {2'h0, 1'b1, 1'b0, 20'h00100 - 20'(i), 20'h00200 + 20'(2 * i)};
         `CHK("block item", exp, itemQ[i]);
      end
      xfer(1'b0, 32'h00000000, 32'h00000000);
      `CHK("block end control", ctl(3'h1, 2'h3, 2'h2, 8'h4C), rd);
      xfer(1'b0, 32'h0000000C, 32'h00000000);
      `CHK("count reload", 32'h00000003, rd);
      xfer(1'b0, 32'h00000004, 32'h00000000);
      `CHK("source pointer kept", 32'h00000100, rd);
      xfer(1'b0, 32'h00000008, 32'h00000000);
      `CHK("dest pointer kept", 32'h00000200, rd);
      `CHK("irq line", 1'b1, irqOut);
      xfer(1'b0, 32'h00000034, 32'h00000000);
      `CHK("vector ch0", 32'h00000002, rd);
      xfer(1'b0, 32'h00000000, 32'h00000000);
      `CHK("flag cleared", ctl(3'h1, 2'h3, 2'h2, 8'h44), rd);
      // Single, edge: triggers while disabled are dropped
      xfer(1'b1, 32'h00000014, 32'h00000300);
      xfer(1'b1, 32'h00000018, 32'h00000400);
      xfer(1'b1, 32'h0000001C, 32'h00000002);
      xfer(1'b1, 32'h00000010, 32'h00000005);
      trigIn[1] <= 1'b1;
      repeat (10) @(posedge clock);
      trigIn[1] <= 1'b0;
      repeat (10) @(posedge clock);
      `CHK("items while disabled", 3, itemQ.size());
      xfer(1'b0, 32'h00000010, 32'h00000000);
      `CHK("request dropped", 32'h00000004, rd);
      xfer(1'b1, 32'h00000010, 32'h00000014);
      trigIn[1] <= 1'b1;
      repeat (20) @(posedge clock);
      `CHK("one item per edge", 4, itemQ.size());
      xfer(1'b0, 32'h0000001C, 32'h00000000);
      `CHK("count step", 32'h00000001, rd);
      trigIn[1] <= 1'b0;
      repeat (3) @(posedge clock);
      trigIn[1] <= 1'b1;
      waitItems(5);
      trigIn[1] <= 1'b0;
      for (i = 3; i < 5; i++) begin
         `CHK("single item", {2'h1, 2'h0, 20'h00300, 20'h00400}, itemQ[i]);
      end
      xfer(1'b0, 32'h00000010, 32'h00000000);
      `CHK("single end control", 32'h0000000C, rd);
      // Zero count blocks even a software start
      xfer(1'b1, 32'h0000002C, 32'h00000000);
      xfer(1'b1, 32'h00000020, 32'h00000011);
      repeat (20) @(posedge clock);
      `CHK("zero count items", 5, itemQ.size());
      // Repeated block, level trigger, word source stepping up
      xfer(1'b1, 32'h00000020, 32'h00000000);
      xfer(1'b1, 32'h0000002C, 32'h00000002);
      xfer(1'b1, 32'h00000024, 32'h00000500);
      xfer(1'b1, 32'h00000028, 32'h00000600);
      xfer(1'b1, 32'h00000020, ctl(3'h4, 2'h1, 2'h3, 8'h30));
      trigIn[2] <= 1'b1;
      waitItems(8);
      trigIn[2] <= 1'b0;
      repeat (10) @(posedge clock);
      for (i = 0; i < 3; i++) begin
         exp = {2'h2, 2'h0, 20'h00500 + 20'(2 * (i % 2)), 20'h00600};
         `CHK("repeat item", exp, itemQ[5 + i]);
      end
      xfer(1'b0, 32'h00000020, 32'h00000000);
      `CHK("repeat stays enabled", 1'b1, rd[BIT_EN]);
      xfer(1'b0, 32'h00000034, 32'h00000000);
      `CHK("vector ch1", 32'h00000004, rd);
      xfer(1'b0, 32'h00000034, 32'h00000000);
      `CHK("vector masked ch2", 32'h00000000, rd);
      xfer(1'b0, 32'h00000020, 32'h00000000);
      `CHK("masked flag kept", 1'b1, rd[BIT_IFG]);
      xfer(1'b1, 32'h00000020, 32'h00000000);
      // NMI with abort off, then on
      slowMode <= 1'b1;
      xfer(1'b1, 32'h0000000C, 32'h00000002);
      base = itemQ.size();
      xfer(1'b1, 32'h00000000, ctl(3'h1, 2'h0, 2'h0, 8'h11));
      waitValid();
      nmiIn <= 1'b1;
      @(posedge clock);
      nmiIn <= 1'b0;
      waitItems(base + 2);
      xfer(1'b0, 32'h00000000, 32'h00000000);
      `CHK("no abort when off", 1'b0, rd[BIT_ABORT]);
      xfer(1'b1, 32'h00000030, 32'h00000001);
      base = itemQ.size();
      xfer(1'b1, 32'h00000000, ctl(3'h1, 2'h0, 2'h0, 8'h11));
      waitValid();
      nmiIn <= 1'b1;
      @(posedge clock);
      nmiIn <= 1'b0;
      repeat (40) @(posedge clock);
      `CHK("items after abort", base + 1, itemQ.size());
      xfer(1'b0, 32'h00000000, 32'h00000000);
      `CHK("abort flag", 1'b1, rd[BIT_ABORT]);
      `CHK("aborted disabled", 1'b0, rd[BIT_EN]);
      xfer(1'b1, 32'h00000030, 32'h00000000);
      conclude();
   end
endmodule
`default_nettype wire
